// >>> core/lam_pkg.sv
// Package with the register map, field layout, reset values and carriers of the limit alarm monitor.
package lam_pkg;
    localparam int LAM_NCH = 8;
    localparam int LAM_NTEMP = 3;
    localparam int LAM_DW = 12;
    localparam int LAM_CW = 8;
    // Register byte offsets on the Wishbone bus.
    localparam logic [7:0] LAM_OFS_GSTAT = 8'h00;
    localparam logic [7:0] LAM_OFS_ALIVE = 8'h04;
    localparam logic [7:0] LAM_OFS_ISTAT = 8'h08;
    localparam logic [7:0] LAM_OFS_IMASK = 8'h0c;
    localparam logic [7:0] LAM_OFS_ROUTE = 8'h10;
    localparam logic [7:0] LAM_OFS_OCFG = 8'h14;
    localparam logic [7:0] LAM_OFS_FILT = 8'h18;
    localparam logic [7:0] LAM_OFS_LIM = 8'h20;
    localparam logic [2:0] LAM_LIM_PAGE = 3'h1;
    // Field positions.
    localparam int LAM_LIM_LO_LSB = 0;
    localparam int LAM_LIM_HI_LSB = 16;
    localparam int LAM_FILT_CH_LSB = 0;
    localparam int LAM_FILT_TEMP_LSB = 8;
    localparam int LAM_OCFG_POL_BIT = 0;
    // Values after reset.
    localparam logic [LAM_CW-1:0] LAM_RST_CH_COUNT = 8'h10;
    localparam logic [LAM_CW-1:0] LAM_RST_TEMP_COUNT = 8'h04;
    localparam logic [LAM_DW-1:0] LAM_RST_LIM_LO = 12'h000;
    localparam logic [LAM_DW-1:0] LAM_RST_LIM_HI = 12'hfff;
    localparam logic [LAM_NCH-1:0] LAM_RST_MASK = 8'h00;
    localparam logic [LAM_NCH-1:0] LAM_RST_ROUTE = 8'h00;
    localparam logic LAM_RST_POL = 1'b0;

    // One conversion result from the converter sequencer.
    typedef struct packed {
        logic valid;
        logic [2:0] ch;
        logic [LAM_DW-1:0] data;
    } lam_conv_t;

    // Live condition levels shown in the general status register.
    typedef struct packed {
        logic global_data_available_flag;
        logic sleep_two;
        logic sleep_one;
        logic power_amp_on_flag;
    } lam_gstat_t;
endpackage

// >>> core/lam_limit_alarm_monitor.sv
// Limit alarm monitor: window compare, consecutive-sample filter, alarm pin and Wishbone registers.
// Summary of operation
// - Flag alarm when value leaves limit window.
// - Channel alarm after configurable consecutive count, default sixteen.
// - Temperature inputs own filter, default four.
// - Per-source routing enable drives alarm pin.
// - Alarm pin active low; polarity bit inverts.
// - General status flags zero at reset.
// - Host writes limits, reads alarm states.
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module lam_limit_alarm_monitor
    import lam_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Conversion results and condition levels.
    input wire lam_conv_t conv_i,
    input wire lam_gstat_t gstat_i,
    // Alarm pin and interrupt.
    output logic alarm_out_o,
    output logic irq_o
);
    logic [LAM_DW-1:0] lim_lo_ff [LAM_NCH];
    logic [LAM_DW-1:0] lim_hi_ff [LAM_NCH];
    logic [LAM_CW-1:0] cnt_ff [LAM_NCH];
    logic [LAM_NCH-1:0] alarm_ff;
    logic [LAM_NCH-1:0] istat_ff;
    logic [LAM_NCH-1:0] imask_ff;
    logic [LAM_NCH-1:0] route_ff;
    logic pol_ff;
    logic [LAM_CW-1:0] ch_count_ff;
    logic [LAM_CW-1:0] temp_count_ff;
    lam_gstat_t gstat_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic alarm_pin_ff;
    logic irq_ff;
    logic acc;
    logic wr;
    logic lim_sel;
    logic [2:0] lim_idx;
    logic conv_out;
    logic [LAM_CW-1:0] conv_thr;
    logic [LAM_NCH-1:0] nxt_alarm;
    logic [LAM_NCH-1:0] alarm_rise;
    logic [LAM_NCH-1:0] w1c;
    logic [31:0] nxt_rdat;
    logic [31:0] lim_word;
    logic [31:0] w1c_word;
    logic [31:0] imask_word;
    logic [31:0] route_word;
    logic [31:0] ocfg_word;
    logic [31:0] filt_word;
    logic [31:0] lim_wr_word;

    // Byte-lane merge of a write into the old register contents.
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Consecutive-sample count that a channel must reach; zero acts as one.
    function automatic logic [LAM_CW-1:0] thr_of(input logic [2:0] ch, input logic [LAM_CW-1:0] cc,
                                                input logic [LAM_CW-1:0] tc);
        logic [LAM_CW-1:0] t;
        t = (32'(ch) < LAM_NTEMP) ? tc : cc;
        return (t == '0) ? LAM_CW'(1) : t;
    endfunction

    assign acc = cyc_i && stb_i && !ack_ff;
    assign wr = acc && we_i;
    assign lim_sel = (adr_i[7:5] == LAM_LIM_PAGE);
    assign lim_idx = adr_i[4:2];
    assign lim_word = {4'h0, lim_hi_ff[lim_idx], 4'h0, lim_lo_ff[lim_idx]};

    // Write data merged by byte lane into each register's present word, the clear mask into zero. The registers
    // take their fields from these words, so a partial write keeps the untouched lanes.
    assign w1c_word = wmerge(32'h0, dat_i, sel_i);
    assign imask_word = wmerge(32'(imask_ff), dat_i, sel_i);
    assign route_word = wmerge(32'(route_ff), dat_i, sel_i);
    assign ocfg_word = wmerge(32'(pol_ff), dat_i, sel_i);
    assign filt_word = wmerge({16'h0, temp_count_ff, ch_count_ff}, dat_i, sel_i);
    assign lim_wr_word = wmerge(lim_word, dat_i, sel_i);

    // Window compare of the incoming result.
    assign conv_out = (conv_i.data > lim_hi_ff[conv_i.ch]) || (conv_i.data < lim_lo_ff[conv_i.ch]);
    assign conv_thr = thr_of(conv_i.ch, ch_count_ff, temp_count_ff);

    // Consecutive-sample counters. The count saturates at the threshold so that a
    // long excursion never wraps back below it and drops the alarm.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < LAM_NCH; i++) begin
                cnt_ff[i] <= '0;
            end
        end else if (conv_i.valid) begin
            if (!conv_out) begin
                cnt_ff[conv_i.ch] <= '0;
            end else if (cnt_ff[conv_i.ch] < conv_thr) begin
                cnt_ff[conv_i.ch] <= cnt_ff[conv_i.ch] + LAM_CW'(1);
            end
        end
    end

    always_comb begin
        nxt_alarm = alarm_ff;
        if (conv_i.valid) begin
            if (!conv_out) begin
                nxt_alarm[conv_i.ch] = 1'b0;
            end else if (cnt_ff[conv_i.ch] + LAM_CW'(1) >= conv_thr) begin
                nxt_alarm[conv_i.ch] = 1'b1;
            end
        end
    end

    assign alarm_rise = nxt_alarm & ~alarm_ff;

    // Alarms track every channel whose results arrive on the conversion input.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_ff <= '0;
        end else begin
            alarm_ff <= nxt_alarm;
        end
    end

    // Alarm pin: routed alarms drive it to the active level, low unless inverted.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_pin_ff <= 1'b1;
        end else begin
            alarm_pin_ff <= (|(alarm_ff & route_ff)) ~^ pol_ff;
        end
    end

    assign alarm_out_o = alarm_pin_ff;

    // Condition flags are sampled so a read sees a stable word.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gstat_ff <= '0;
        end else begin
            gstat_ff <= gstat_i;
        end
    end

    // Sticky interrupt status; a new alarm in the same cycle as its clear stays set.
    assign w1c = (wr && adr_i == LAM_OFS_ISTAT) ? w1c_word[LAM_NCH-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            istat_ff <= '0;
        end else begin
            istat_ff <= (istat_ff & ~w1c) | alarm_rise;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(istat_ff & imask_ff);
        end
    end

    assign irq_o = irq_ff;

    // Control registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            imask_ff <= LAM_RST_MASK;
            route_ff <= LAM_RST_ROUTE;
            pol_ff <= LAM_RST_POL;
            ch_count_ff <= LAM_RST_CH_COUNT;
            temp_count_ff <= LAM_RST_TEMP_COUNT;
        end else if (wr) begin
            case (adr_i)
                LAM_OFS_IMASK: begin
                    imask_ff <= imask_word[LAM_NCH-1:0];
                end
                LAM_OFS_ROUTE: begin
                    route_ff <= route_word[LAM_NCH-1:0];
                end
                LAM_OFS_OCFG: begin
                    pol_ff <= ocfg_word[LAM_OCFG_POL_BIT];
                end
                LAM_OFS_FILT: begin
                    ch_count_ff <= filt_word[LAM_FILT_CH_LSB +: LAM_CW];
                    temp_count_ff <= filt_word[LAM_FILT_TEMP_LSB +: LAM_CW];
                end
                default: begin
                end
            endcase
        end
    end

    // Limit registers, one word per channel.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < LAM_NCH; i++) begin
                lim_lo_ff[i] <= LAM_RST_LIM_LO;
                lim_hi_ff[i] <= LAM_RST_LIM_HI;
            end
        end else if (wr && lim_sel) begin
            lim_lo_ff[lim_idx] <= lim_wr_word[LAM_LIM_LO_LSB +: LAM_DW];
            lim_hi_ff[lim_idx] <= lim_wr_word[LAM_LIM_HI_LSB +: LAM_DW];
        end
    end

    // Read multiplexer; unmapped offsets answer with zero.
    always_comb begin
        nxt_rdat = 32'h0;
        if (lim_sel) begin
            nxt_rdat = lim_word;
        end else begin
            case (adr_i)
                LAM_OFS_GSTAT: nxt_rdat = 32'(gstat_ff);
                LAM_OFS_ALIVE: nxt_rdat = 32'(alarm_ff);
                LAM_OFS_ISTAT: nxt_rdat = 32'(istat_ff);
                LAM_OFS_IMASK: nxt_rdat = 32'(imask_ff);
                LAM_OFS_ROUTE: nxt_rdat = 32'(route_ff);
                LAM_OFS_OCFG: nxt_rdat = 32'(pol_ff);
                LAM_OFS_FILT: nxt_rdat = {16'h0, temp_count_ff, ch_count_ff};
                default: nxt_rdat = 32'h0;
            endcase
        end
    end

    // Every access is answered one cycle after it is seen, so ack never stalls the master.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0;
        end else begin
            ack_ff <= acc;
            if (acc && !we_i) begin
                rdat_ff <= nxt_rdat;
            end
        end
    end

    assign ack_o = ack_ff;
    assign dat_o = rdat_ff;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_inrange_clears: assert property (conv_i.valid && !conv_out |=> !alarm_ff[$past(conv_i.ch)])
        else $error("in-range result left alarm set");
    a_inrange_restart: assert property (conv_i.valid && !conv_out |=> cnt_ff[$past(conv_i.ch)] == 0)
        else $error("counter not restarted");
    a_count_reached: assert property (conv_i.valid && conv_out &&
        (cnt_ff[conv_i.ch] + LAM_CW'(1) >= conv_thr) |=> alarm_ff[$past(conv_i.ch)])
        else $error("alarm missing at threshold");
    a_count_early: assert property (conv_i.valid && conv_out && !alarm_ff[conv_i.ch] &&
        (cnt_ff[conv_i.ch] + LAM_CW'(1) < conv_thr) |=> !alarm_ff[$past(conv_i.ch)])
        else $error("alarm before threshold");
    a_pin_level: assert property (##1 alarm_out_o == ((|($past(alarm_ff) & $past(route_ff))) ~^ $past(pol_ff)))
        else $error("alarm pin level wrong");
    a_pin_idle: assert property (route_ff == '0 && $past(route_ff) == '0 |=> alarm_out_o == !$past(pol_ff))
        else $error("alarm pin not idle");
    a_gstat_follow: assert property (##1 gstat_ff == $past(gstat_i))
        else $error("status flags do not follow");
    a_live_read: assert property (acc && !we_i && adr_i == LAM_OFS_ALIVE |=> ack_o && dat_o == 32'($past(alarm_ff)))
        else $error("alarm state read wrong");
    a_sticky_wins: assert property ((w1c & alarm_rise) != '0 |=> (istat_ff & $past(w1c & alarm_rise)) != '0)
        else $error("set lost to clear");
    a_irq_level: assert property ((istat_ff & imask_ff) != '0 |=> irq_o)
        else $error("irq missing");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held");

    // Bus side: every seen access is answered, and writes land in the addressed word.
    a_ack_follows: assert property (acc |=> ack_o)
        else $error("access not acknowledged");
    a_lim_write: assert property (wr && lim_sel && sel_i == 4'hf |=>
        lim_lo_ff[$past(lim_idx)] == $past(dat_i[11:0]) && lim_hi_ff[$past(lim_idx)] == $past(dat_i[27:16]))
        else $error("limit write lost");
    a_gstat_read: assert property (acc && !we_i && adr_i == LAM_OFS_GSTAT |=> dat_o == 32'($past(gstat_ff)))
        else $error("status read wrong");
    a_route_write: assert property (wr && adr_i == LAM_OFS_ROUTE && sel_i[0] |=> route_ff == $past(dat_i[7:0]))
        else $error("routing write lost");
    a_pol_write: assert property (wr && adr_i == LAM_OFS_OCFG && sel_i[0] |=> pol_ff == $past(dat_i[0]))
        else $error("polarity write lost");
    a_filt_write: assert property (wr && adr_i == LAM_OFS_FILT && sel_i[1:0] == 2'h3 |=>
        ch_count_ff == $past(dat_i[7:0]) && temp_count_ff == $past(dat_i[15:8]))
        else $error("filter count write lost");

    // Alarm state only moves on a result; the sticky status latches each new alarm.
    a_alarm_hold: assert property (!conv_i.valid |=> alarm_ff == $past(alarm_ff))
        else $error("alarm moved without a result");
    a_istat_set: assert property (alarm_rise != '0 |=> (istat_ff & $past(alarm_rise)) == $past(alarm_rise))
        else $error("new alarm not latched");
    a_istat_clear: assert property (w1c != '0 && alarm_rise == '0 |=> (istat_ff & $past(w1c)) == '0)
        else $error("status bit not cleared");
    a_irq_quiet: assert property ((istat_ff & imask_ff) == '0 |=> !irq_o)
        else $error("irq without source");

    c_alarm_trip: cover property (alarm_rise != '0 ##1 !alarm_out_o);
    c_alarm_recover: cover property ($fell(alarm_ff[0]));
    c_limit_write: cover property (wr && lim_sel ##1 ack_o);
    c_irq: cover property ($rose(irq_o));
    c_temp_trip: cover property (conv_i.valid && conv_i.ch == 3'h0 && alarm_rise[0]);
endmodule

// >>> tb/lam_limit_alarm_monitor_test.sv
// Self-checking testbench of the limit alarm monitor.
`timescale 1ns/1ps
module lam_limit_alarm_monitor_test;
    import lam_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    lam_conv_t conv_i = '0;
    lam_gstat_t gstat_i = '0;
    logic alarm_out_o;
    logic irq_o;
    logic [31:0] rd;
    int mismatches = 0;
    int checks_done = 0;

    always #12.5 clk_i = ~clk_i;

    lam_limit_alarm_monitor i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .conv_i(conv_i),
        .gstat_i(gstat_i), .alarm_out_o(alarm_out_o), .irq_o(irq_o));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // The request stays up until ack is sampled; a stuck slave ends the run.
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= adr;
        dat_i <= wd;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            mismatches++;
            $display("bus access timed out");
            tally_and_finish();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string what);
        wb(1'b0, adr, 32'h0);
        check(what, rd, exp);
    endtask

    task automatic lim(input int ch, input logic [11:0] lo, input logic [11:0] hi);
        wb(1'b1, LAM_OFS_LIM + 8'(4 * ch), {4'h0, hi, 4'h0, lo});
    endtask

    // Back-to-back results, then a few idle cycles for the alarm and pin to settle.
    task automatic feed(input logic [2:0] ch, input logic [11:0] d, input int n);
        repeat (n) begin
            conv_i <= '{1'b1, ch, d};
            @(posedge clk_i);
        end
        conv_i.valid <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic t_reset();
        rd_chk(LAM_OFS_GSTAT, 32'h0, "gstat");
        rd_chk(LAM_OFS_FILT, 32'h00000410, "filter counts");
        rd_chk(LAM_OFS_LIM + 8'h0c, 32'h0fff0000, "limit ch3");
        rd_chk(8'hfc, 32'h0, "unmapped");
        check("alarm pin", alarm_out_o, 32'h1);
        check("irq", irq_o, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_status();
        gstat_i <= 4'ha;
        repeat (2) @(posedge clk_i);
        rd_chk(LAM_OFS_GSTAT, 32'ha, "gstat a");
        gstat_i <= 4'h5;
        repeat (2) @(posedge clk_i);
        rd_chk(LAM_OFS_GSTAT, 32'h5, "gstat 5");
        $display("test status done");
    endtask

    task automatic t_channel();
        lim(3, 12'h100, 12'h200);
        rd_chk(LAM_OFS_LIM + 8'h0c, 32'h02000100, "limit ch3");
        feed(3'd3, 12'h201, 15);
        feed(3'd3, 12'h150, 1);
        feed(3'd3, 12'h201, 15);
        rd_chk(LAM_OFS_ALIVE, 32'h0, "alarm after 15");
        feed(3'd3, 12'h201, 1);
        rd_chk(LAM_OFS_ALIVE, 32'h8, "alarm after 16");
        rd_chk(LAM_OFS_ISTAT, 32'h8, "istat");
        check("irq masked", irq_o, 32'h0);
        $display("test channel done");
    endtask

    task automatic t_temp();
        lim(0, 12'h010, 12'h020);
        feed(3'd0, 12'h00f, 3);
        rd_chk(LAM_OFS_ALIVE, 32'h8, "temp after 3");
        feed(3'd0, 12'h00f, 1);
        rd_chk(LAM_OFS_ALIVE, 32'h9, "temp after 4");
        feed(3'd0, 12'h010, 1);
        rd_chk(LAM_OFS_ALIVE, 32'h8, "temp at low edge");
        $display("test temperature done");
    endtask

    task automatic t_pin();
        check("pin unrouted", alarm_out_o, 32'h1);
        wb(1'b1, LAM_OFS_ROUTE, 32'h8);
        repeat (2) @(posedge clk_i);
        check("pin routed", alarm_out_o, 32'h0);
        wb(1'b1, LAM_OFS_OCFG, 32'h1);
        repeat (2) @(posedge clk_i);
        check("pin inverted", alarm_out_o, 32'h1);
        wb(1'b1, LAM_OFS_ROUTE, 32'h1);
        repeat (2) @(posedge clk_i);
        check("pin quiet source", alarm_out_o, 32'h0);
        $display("test pin done");
    endtask

    task automatic t_irq();
        wb(1'b1, LAM_OFS_IMASK, 32'h8);
        repeat (2) @(posedge clk_i);
        check("irq on", irq_o, 32'h1);
        wb(1'b1, LAM_OFS_ISTAT, 32'h8);
        repeat (2) @(posedge clk_i);
        check("irq cleared", irq_o, 32'h0);
        rd_chk(LAM_OFS_ISTAT, 32'h1, "istat after clear");
        rd_chk(LAM_OFS_IMASK, 32'h8, "mask");
        $display("test interrupt done");
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_reset();
        t_status();
        t_channel();
        t_temp();
        t_pin();
        t_irq();
        tally_and_finish();
    end
endmodule
